/* src/scan_xcvr_map.svh */
// Constants for the scan-wrapped bus transceiver: widths, opcodes, fields.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SCAN_XCVR_MAP_SVH
`define SCAN_XCVR_MAP_SVH
`define BUS_W 20
`define IR_W 8
`define BSR_W 88
`define BCR_W 23
`define ID_W 32
`define IR_CAPTURE 8'h81
`define OP_EXTEST 8'h00
`define OP_SAMPLE 8'h81
`define OP_IDCODE 8'h82
`define OP_HIGHZ 8'h06
`define OP_RUNT 8'h09
`define OP_SCANBCR 8'h0A
`define OP_BYPASS 8'hFF
// Arbitrary neutral identification value
`define ID_DEFAULT 32'h0000_0001
`define BSR_AIN_LSB 7'h08
`define BSR_AOUT_LSB 7'h1C
`define BSR_BIN_LSB 7'h30
`define BSR_BOUT_LSB 7'h44
`define CTRL_AB_OE 3
`define CTRL_BA_OE 7
`define BCR_OP_LSB 0
`define BCR_DIR 2
`define BCR_MASK_LSB 3
`define RUN_PSA 2'h1
`define RUN_PRPG 2'h2
`define RUN_COUNT 2'h3
`define LFSR_TAP_A 19
`define LFSR_TAP_B 16
`define TLR_TMS_CYCLES 3'h5
`define SYNC_RST_LOW 11'h443
`endif

/* src/scan_xcvr_pkg.sv */
// Types shared by the scan-wrapped bus transceiver.
// Assumes the map header sits on the include path.
`default_nettype none
`include "scan_xcvr_map.svh"
package scan_xcvr_pkg;
    typedef struct packed {
        logic oe_n;
        logic le;
        logic clken_n;
        logic clk;
    } dir_ctrl_t;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;
    typedef enum logic [3:0] {
        TLR = 4'b1111, RTI = 4'b1100, SEL_DR = 4'b0111, CAP_DR = 4'b0110,
        SH_DR = 4'b0010, EX1_DR = 4'b0001, PAU_DR = 4'b0011,
        EX2_DR = 4'b0000, UPD_DR = 4'b0101, SEL_IR = 4'b0100,
        CAP_IR = 4'b1110, SH_IR = 4'b1010, EX1_IR = 4'b1001,
        PAU_IR = 4'b1011, EX2_IR = 4'b1000, UPD_IR = 4'b1101
    } tap_state_t;
    typedef enum logic [1:0] {
        SEL_BSR = 2'b00, SEL_BCR = 2'b01, SEL_BYP = 2'b10, SEL_ID = 2'b11
    } dr_sel_t;
endpackage
`default_nettype wire

/* src/scan_xcvr.sv */
// Scan-wrapped 20-bit registered bus transceiver with a serial test port.
// Assumes every pin and the test clock arrive asynchronously to CLK_I,
// which must run well above the test clock and the bus clocks.
//
// Functional notes
// - Each direction carries twenty data bits between the A and B buses.
// - A-to-B latch enable high makes B follow A transparently.
// - Latch enable low with clock enable high or static clock holds B.
// - Latch and clock enable low store A on each rising A-to-B clock.
// - A-to-B output enable low drives B; high floats B.
// - B-to-A flow works the same with its own four controls.
// - Test mode inhibits normal flow; test logic controls the boundary.
// - Test port activity in normal mode leaves data paths undisturbed.
// - Two boundary cells per data pin, captured and forced per side.
// - Test inputs sampled on test clock rise, outputs change on fall.
// - Serial test data input reads high when undriven.
// - Test mode select reads high when undriven.
// - Serial output shifts instruction or selected data register bits.
// - Only test clock and mode select advance the test state machine.
// - Instruction register is eight bits long.
// - Data registers: 88 boundary, 23 control, 1 bypass, 32 identity.
// - Signature compression on inputs, pseudo-random patterns on outputs.
// - Combined mode compresses inputs while counting on the outputs.
// - Test operations follow the standard four-wire access protocol.
// - Mode select held high reaches reset state within five clocks.
// - Instruction capture loads the pattern 10000001.
// - New instruction takes effect on falling clock in update state.
// - Serial output enables on first falling clock in shift state.
`default_nettype none
`include "scan_xcvr_map.svh"
module scan_xcvr #(
    // Arbitrary identification value
    parameter logic [`ID_W-1:0] ID_CODE = `ID_DEFAULT
) (
    // System
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // A bus pins
    input wire logic [`BUS_W-1:0] A_I,
    output logic [`BUS_W-1:0] A_O,
    output logic A_OE_O,
    // B bus pins
    input wire logic [`BUS_W-1:0] B_I,
    output logic [`BUS_W-1:0] B_O,
    output logic B_OE_O,
    // A-to-B controls
    input wire logic A_TO_B_OUTPUT_ENABLE_N_I,
    input wire logic A_TO_B_LATCH_ENABLE_I,
    input wire logic A_TO_B_CLOCK_ENABLE_N_I,
    input wire logic A_TO_B_CLOCK_I,
    // B-to-A controls
    input wire logic B_TO_A_OUTPUT_ENABLE_N_I,
    input wire logic B_TO_A_LATCH_ENABLE_I,
    input wire logic B_TO_A_CLOCK_ENABLE_N_I,
    input wire logic B_TO_A_CLOCK_I,
    // Test port
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    output logic TDO_O,
    output logic TDO_OE_O
);
    localparam int SYNC_W = 2 * `BUS_W + 11;

    logic [SYNC_W-1:0] raw, s1_ff, s2_ff;
    logic [`BUS_W-1:0] a_s, b_s;
    scan_xcvr_pkg::dir_ctrl_t ab_c, ba_c;
    scan_xcvr_pkg::tap_pins_t tp;
    scan_xcvr_pkg::dir_ctrl_t ctrl [2];
    logic [`BUS_W-1:0] src [2];
    logic [`BUS_W-1:0] tst_dat [2];
    logic tst_oe_n [2];
    logic [`BUS_W-1:0] out_ff [2];
    logic oe_ff [2];
    logic clk_d_ff [2];
    logic tck_d_ff, tck_rise, tck_fall;
    scan_xcvr_pkg::tap_state_t state_ff, nxt_state;
    logic [`IR_W-1:0] ir_ff, ir_sh_ff;
    logic [`BSR_W-1:0] bsr_sh_ff, bsr_upd_ff, bsr_cap;
    logic [`BCR_W-1:0] bcr_sh_ff, bcr_upd_ff;
    logic byp_ff;
    logic [`ID_W-1:0] id_sh_ff;
    scan_xcvr_pkg::dr_sel_t sel;
    logic test_mode, highz, dr_lsb, tdo_ff, tdo_oe_ff;
    logic [6:0] in_lsb, out_lsb;
    logic [`BUS_W-1:0] sig, pat, sig_nxt, pat_nxt, mask, in_data;
    logic [1:0] run_op;
    logic [2:0] tms_hi_cnt_ff;

    function automatic logic [`BUS_W-1:0] lfsr(input logic [`BUS_W-1:0] s);
        // Inverted feedback so an all-zero start still walks
        lfsr = {s[`BUS_W-2:0], ~(s[`LFSR_TAP_A] ^ s[`LFSR_TAP_B])};
    endfunction

    // Pin synchronisers; mode select, data input and output enables idle
    // high, so neither bus is driven while the first samples arrive
    assign raw = {A_I, B_I,
                  B_TO_A_OUTPUT_ENABLE_N_I, B_TO_A_LATCH_ENABLE_I,
                  B_TO_A_CLOCK_ENABLE_N_I, B_TO_A_CLOCK_I,
                  A_TO_B_OUTPUT_ENABLE_N_I, A_TO_B_LATCH_ENABLE_I,
                  A_TO_B_CLOCK_ENABLE_N_I, A_TO_B_CLOCK_I,
                  TCK_I, TMS_I, TDI_I};

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s1_ff <= {{(2 * `BUS_W){1'b0}}, `SYNC_RST_LOW};
            s2_ff <= {{(2 * `BUS_W){1'b0}}, `SYNC_RST_LOW};
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
        end
    end

    assign {a_s, b_s, ba_c, ab_c, tp} = s2_ff;
    assign ctrl[0] = ab_c;
    assign ctrl[1] = ba_c;
    assign src[0] = a_s;
    assign src[1] = b_s;
    assign tst_dat[0] = bsr_upd_ff[`BSR_BOUT_LSB +: `BUS_W];
    assign tst_dat[1] = bsr_upd_ff[`BSR_AOUT_LSB +: `BUS_W];
    assign tst_oe_n[0] = bsr_upd_ff[`CTRL_AB_OE];
    assign tst_oe_n[1] = bsr_upd_ff[`CTRL_BA_OE];

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            tck_d_ff <= 1'b0;
        end else begin
            tck_d_ff <= tp.tck;
        end
    end

    assign tck_rise = tp.tck & ~tck_d_ff;
    assign tck_fall = ~tp.tck & tck_d_ff;

    // Both directions share one datapath; index 0 is A to B
    for (genvar d = 0; d < 2; d++) begin : g_dir
        always_ff @(posedge CLK_I) begin
            if (SYS_RST_I) begin
                out_ff[d] <= '0;
                oe_ff[d] <= 1'b0;
                clk_d_ff[d] <= 1'b0;
            end else begin
                clk_d_ff[d] <= ctrl[d].clk;
                if (test_mode) begin
                    // Held value is replaced while the boundary drives
                    out_ff[d] <= tst_dat[d];
                    oe_ff[d] <= ~tst_oe_n[d] & ~highz;
                end else begin
                    oe_ff[d] <= ~ctrl[d].oe_n;
                    if (ctrl[d].le) begin
                        out_ff[d] <= src[d];
                    end else if (!ctrl[d].clken_n &&
                                 ctrl[d].clk && !clk_d_ff[d]) begin
                        out_ff[d] <= src[d];
                    end
                end
            end
        end
    end

    assign B_O = out_ff[0];
    assign B_OE_O = oe_ff[0];
    assign A_O = out_ff[1];
    assign A_OE_O = oe_ff[1];

    // Test state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            scan_xcvr_pkg::TLR: nxt_state = tp.tms ? scan_xcvr_pkg::TLR : scan_xcvr_pkg::RTI;
            scan_xcvr_pkg::RTI: nxt_state = tp.tms ? scan_xcvr_pkg::SEL_DR : scan_xcvr_pkg::RTI;
            scan_xcvr_pkg::SEL_DR: nxt_state = tp.tms ? scan_xcvr_pkg::SEL_IR : scan_xcvr_pkg::CAP_DR;
            scan_xcvr_pkg::CAP_DR: nxt_state = tp.tms ? scan_xcvr_pkg::EX1_DR : scan_xcvr_pkg::SH_DR;
            scan_xcvr_pkg::SH_DR: nxt_state = tp.tms ? scan_xcvr_pkg::EX1_DR : scan_xcvr_pkg::SH_DR;
            scan_xcvr_pkg::EX1_DR: nxt_state = tp.tms ? scan_xcvr_pkg::UPD_DR : scan_xcvr_pkg::PAU_DR;
            scan_xcvr_pkg::PAU_DR: nxt_state = tp.tms ? scan_xcvr_pkg::EX2_DR : scan_xcvr_pkg::PAU_DR;
            scan_xcvr_pkg::EX2_DR: nxt_state = tp.tms ? scan_xcvr_pkg::UPD_DR : scan_xcvr_pkg::SH_DR;
            scan_xcvr_pkg::UPD_DR: nxt_state = tp.tms ? scan_xcvr_pkg::SEL_DR : scan_xcvr_pkg::RTI;
            scan_xcvr_pkg::SEL_IR: nxt_state = tp.tms ? scan_xcvr_pkg::TLR : scan_xcvr_pkg::CAP_IR;
            scan_xcvr_pkg::CAP_IR: nxt_state = tp.tms ? scan_xcvr_pkg::EX1_IR : scan_xcvr_pkg::SH_IR;
            scan_xcvr_pkg::SH_IR: nxt_state = tp.tms ? scan_xcvr_pkg::EX1_IR : scan_xcvr_pkg::SH_IR;
            scan_xcvr_pkg::EX1_IR: nxt_state = tp.tms ? scan_xcvr_pkg::UPD_IR : scan_xcvr_pkg::PAU_IR;
            scan_xcvr_pkg::PAU_IR: nxt_state = tp.tms ? scan_xcvr_pkg::EX2_IR : scan_xcvr_pkg::PAU_IR;
            scan_xcvr_pkg::EX2_IR: nxt_state = tp.tms ? scan_xcvr_pkg::UPD_IR : scan_xcvr_pkg::SH_IR;
            scan_xcvr_pkg::UPD_IR: nxt_state = tp.tms ? scan_xcvr_pkg::SEL_DR : scan_xcvr_pkg::RTI;
            default: nxt_state = scan_xcvr_pkg::TLR;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            state_ff <= scan_xcvr_pkg::TLR;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    // Instruction register
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ir_sh_ff <= '0;
            ir_ff <= `OP_IDCODE;
        end else begin
            if (tck_rise && state_ff == scan_xcvr_pkg::CAP_IR) begin
                ir_sh_ff <= `IR_CAPTURE;
            end else if (tck_rise && state_ff == scan_xcvr_pkg::SH_IR) begin
                ir_sh_ff <= {tp.tdi, ir_sh_ff[`IR_W-1:1]};
            end
            if (state_ff == scan_xcvr_pkg::TLR) begin
                ir_ff <= `OP_IDCODE;
            end else if (tck_fall && state_ff == scan_xcvr_pkg::UPD_IR) begin
                ir_ff <= ir_sh_ff;
            end
        end
    end

    // Instruction decode
    always_comb begin
        case (ir_ff)
            `OP_EXTEST, `OP_SAMPLE: sel = scan_xcvr_pkg::SEL_BSR;
            `OP_RUNT, `OP_SCANBCR: sel = scan_xcvr_pkg::SEL_BCR;
            `OP_IDCODE: sel = scan_xcvr_pkg::SEL_ID;
            default: sel = scan_xcvr_pkg::SEL_BYP;
        endcase
    end

    assign test_mode = ir_ff == `OP_EXTEST || ir_ff == `OP_HIGHZ ||
                       ir_ff == `OP_RUNT;
    assign highz = ir_ff == `OP_HIGHZ;
    assign bsr_cap = {out_ff[0], b_s, out_ff[1], a_s, ba_c, ab_c};

    // Data register capture and shift
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            bsr_sh_ff <= '0;
            bcr_sh_ff <= '0;
            byp_ff <= 1'b0;
            id_sh_ff <= '0;
        end else if (tck_rise && state_ff == scan_xcvr_pkg::CAP_DR) begin
            case (sel)
                scan_xcvr_pkg::SEL_BSR: bsr_sh_ff <= bsr_cap;
                scan_xcvr_pkg::SEL_BCR: bcr_sh_ff <= bcr_upd_ff;
                scan_xcvr_pkg::SEL_ID: id_sh_ff <= ID_CODE;
                default: byp_ff <= 1'b0;
            endcase
        end else if (tck_rise && state_ff == scan_xcvr_pkg::SH_DR) begin
            case (sel)
                scan_xcvr_pkg::SEL_BSR:
                    bsr_sh_ff <= {tp.tdi, bsr_sh_ff[`BSR_W-1:1]};
                scan_xcvr_pkg::SEL_BCR:
                    bcr_sh_ff <= {tp.tdi, bcr_sh_ff[`BCR_W-1:1]};
                scan_xcvr_pkg::SEL_ID:
                    id_sh_ff <= {tp.tdi, id_sh_ff[`ID_W-1:1]};
                default: byp_ff <= tp.tdi;
            endcase
        end
    end

    // Self-test operations run in idle under the run-test instruction
    assign run_op = bcr_upd_ff[`BCR_OP_LSB +: 2];
    assign mask = bcr_upd_ff[`BCR_MASK_LSB +: `BUS_W];
    assign in_lsb = bcr_upd_ff[`BCR_DIR] ? `BSR_BIN_LSB : `BSR_AIN_LSB;
    assign out_lsb = bcr_upd_ff[`BCR_DIR] ? `BSR_AOUT_LSB : `BSR_BOUT_LSB;
    assign in_data = bcr_upd_ff[`BCR_DIR] ? b_s : a_s;
    assign sig = bsr_upd_ff[in_lsb +: `BUS_W];
    assign pat = bsr_upd_ff[out_lsb +: `BUS_W];
    assign sig_nxt = lfsr(sig) ^ (in_data & mask);
    assign pat_nxt = run_op == `RUN_COUNT ? pat + 1'b1 : lfsr(pat);

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I || state_ff == scan_xcvr_pkg::TLR) begin
            bsr_upd_ff <= '0;
            bcr_upd_ff <= '0;
        end else if (tck_fall && state_ff == scan_xcvr_pkg::UPD_DR) begin
            if (sel == scan_xcvr_pkg::SEL_BSR) begin
                bsr_upd_ff <= bsr_sh_ff;
            end else if (sel == scan_xcvr_pkg::SEL_BCR) begin
                bcr_upd_ff <= bcr_sh_ff;
            end
        end else if (tck_rise && state_ff == scan_xcvr_pkg::RTI &&
                     ir_ff == `OP_RUNT) begin
            if (run_op == `RUN_PSA || run_op == `RUN_COUNT) begin
                bsr_upd_ff[in_lsb +: `BUS_W] <= sig_nxt;
            end
            if (run_op == `RUN_PRPG || run_op == `RUN_COUNT) begin
                bsr_upd_ff[out_lsb +: `BUS_W] <= pat_nxt;
            end
        end
    end

    // Serial output changes only on the falling test clock
    always_comb begin
        case (sel)
            scan_xcvr_pkg::SEL_BSR: dr_lsb = bsr_sh_ff[0];
            scan_xcvr_pkg::SEL_BCR: dr_lsb = bcr_sh_ff[0];
            scan_xcvr_pkg::SEL_ID: dr_lsb = id_sh_ff[0];
            default: dr_lsb = byp_ff;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            tdo_ff <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_ff <= state_ff == scan_xcvr_pkg::SH_IR ||
                         state_ff == scan_xcvr_pkg::SH_DR;
            tdo_ff <= state_ff == scan_xcvr_pkg::SH_IR ?
                      ir_sh_ff[0] : dr_lsb;
        end
    end

    assign TDO_O = tdo_ff;
    assign TDO_OE_O = tdo_oe_ff;

    // Helper: consecutive test clock rises with mode select high
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            tms_hi_cnt_ff <= '0;
        end else if (tck_rise) begin
            if (!tp.tms) begin
                tms_hi_cnt_ff <= '0;
            end else if (tms_hi_cnt_ff != `TLR_TMS_CYCLES) begin
                tms_hi_cnt_ff <= tms_hi_cnt_ff + 3'h1;
            end
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    tms_reset_a: assert property (
        tms_hi_cnt_ff == `TLR_TMS_CYCLES |-> state_ff == scan_xcvr_pkg::TLR)
        else $error("Test state not reset after five high selects");
    ir_capture_a: assert property (
        tck_rise && state_ff == scan_xcvr_pkg::CAP_IR |=>
        ir_sh_ff == `IR_CAPTURE)
        else $error("Instruction capture pattern wrong");
    ir_update_a: assert property (
        tck_fall && state_ff == scan_xcvr_pkg::UPD_IR |=>
        ir_ff == $past(ir_sh_ff))
        else $error("Instruction not updated on falling clock");
    tdo_enable_a: assert property (
        tck_fall && (state_ff == scan_xcvr_pkg::SH_DR ||
        state_ff == scan_xcvr_pkg::SH_IR) |=> TDO_OE_O)
        else $error("Serial output not enabled in shift");
    tdo_timing_a: assert property (
        $changed(TDO_O) || $changed(TDO_OE_O) |-> $past(tck_fall))
        else $error("Serial output changed off the falling clock");
    bypass_delay_a: assert property (
        tck_rise && state_ff == scan_xcvr_pkg::SH_DR &&
        sel == scan_xcvr_pkg::SEL_BYP |=> byp_ff == $past(tp.tdi))
        else $error("Bypass stage did not take serial input");
    b_transparent_a: assert property (
        !test_mode && ab_c.le |=> B_O == $past(a_s))
        else $error("B did not follow A while transparent");
    b_hold_a: assert property (
        !test_mode && !ab_c.le && (ab_c.clken_n ||
        !(ab_c.clk && !clk_d_ff[0])) |=> $stable(B_O))
        else $error("B changed while latched");
    b_clocked_a: assert property (
        !test_mode && !ab_c.le && !ab_c.clken_n && ab_c.clk &&
        !clk_d_ff[0] |=> B_O == $past(a_s))
        else $error("B did not store A on clock rise");
    b_enable_a: assert property (
        !test_mode |=> B_OE_O == !$past(ab_c.oe_n))
        else $error("B enable does not follow its control");
    test_drive_a: assert property (
        test_mode && !highz |=> A_O == $past(tst_dat[1]))
        else $error("Boundary did not drive A in test mode");
    bsr_capture_a: assert property (
        tck_rise && state_ff == scan_xcvr_pkg::CAP_DR &&
        sel == scan_xcvr_pkg::SEL_BSR |=> bsr_sh_ff == $past(bsr_cap))
        else $error("Boundary capture wrong");
endmodule
`default_nettype wire

/* test/scan_host_model.sv */
// Far-side test controller: drives the serial test port pins.
// Assumes the bench clock; one test clock spans eight system clocks.
`default_nettype none
module scan_host_model (
    // System
    input wire logic clk_i,
    // Serial port
    input wire logic tdo_i,
    output var scan_xcvr_pkg::tap_pins_t pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pulled-up lines rest high, test clock rests low between frames
    initial pins_o = 3'b011;

    // Inputs move only while the test clock is low; period of eight clocks
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        @(posedge clk_i) #2;
        pins_o.tms = tms;
        pins_o.tdi = tdi;
        repeat (3) @(posedge clk_i);
        #2 pins_o.tck = 1'b1;
        repeat (4) @(posedge clk_i);
        #2 tdo = tdo_i;
        pins_o.tck = 1'b0;
        pins_o.tdi = 1'b1;
    endtask

    // Five clocks with select high, then park in idle
    task automatic home();
        logic t;
        repeat (5) tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
    endtask

    // Full scan from idle back to idle, least significant bit first
    task automatic scan(input bit ir, input int n, input logic [87:0] din,
                        output logic [87:0] dout);
        logic t;
        dout = '0;
        tick(1'b1, 1'b1, t);
        if (ir) tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
        tick(1'b0, 1'b1, t);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], t);
            dout[i] = t;
        end
        tick(1'b1, 1'b1, t);
        tick(1'b0, 1'b1, t);
    endtask
endmodule
`default_nettype wire

/* test/tb_scan_xcvr.sv */
// Self-checking bench for the scan-wrapped transceiver.
// Assumes the design carries its own assertions inside.
`default_nettype none
module tb_scan_xcvr;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID_TB = 32'h5A3C_0F01; // Arbitrary value
    logic clk, rst, a_oe, b_oe, tdo, tdo_oe, tdo_pin, tq;
    logic [19:0] a_drv, b_drv, a_pad, b_pad, a_o, b_o, a_v, b_v;
    logic [87:0] scan_out, din, exp_q[$];
    logic [7:0] r;
    int sel_q[$];
    int mismatches, checks;
    event result_ev;
    scan_xcvr_pkg::dir_ctrl_t ab, ba;
    scan_xcvr_pkg::tap_pins_t tp;

    // Pads show the device while it drives, else the board
    assign a_pad = a_oe ? a_o : a_drv;
    assign b_pad = b_oe ? b_o : b_drv;
    // Released serial line is not held, so show the inverse
    assign tdo_pin = tdo_oe ? tdo : ~tdo;

    scan_xcvr #(.ID_CODE(ID_TB)) scan_xcvr_i (
        .CLK_I(clk), .SYS_RST_I(rst),
        .A_I(a_pad), .A_O(a_o), .A_OE_O(a_oe),
        .B_I(b_pad), .B_O(b_o), .B_OE_O(b_oe),
        .A_TO_B_OUTPUT_ENABLE_N_I(ab.oe_n), .A_TO_B_LATCH_ENABLE_I(ab.le),
        .A_TO_B_CLOCK_ENABLE_N_I(ab.clken_n), .A_TO_B_CLOCK_I(ab.clk),
        .B_TO_A_OUTPUT_ENABLE_N_I(ba.oe_n), .B_TO_A_LATCH_ENABLE_I(ba.le),
        .B_TO_A_CLOCK_ENABLE_N_I(ba.clken_n), .B_TO_A_CLOCK_I(ba.clk),
        .TCK_I(tp.tck), .TMS_I(tp.tms), .TDI_I(tp.tdi),
        .TDO_O(tdo), .TDO_OE_O(tdo_oe));

    scan_host_model scan_host_model_i (
        .clk_i(clk), .tdo_i(tdo_pin), .pins_o(tp));

    function automatic logic [87:0] seen(input int k);
        case (k)
            0: return {67'h0, b_oe, b_o};
            1: return {67'h0, a_oe, a_o};
            2: return scan_out;
            3: return {86'h0, b_oe, a_oe};
            default: return {48'h0, scan_out[67:48], scan_out[27:8]};
        endcase
    endfunction

    task automatic check(input logic [87:0] s, input logic [87:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic note(input int k, input logic [87:0] e);
        exp_q.push_back(e);
        sel_q.push_back(k);
        ->result_ev;
        #1;
    endtask

    // Pins need several system clocks to pass the synchronisers
    task automatic ctl(input bit d, input logic [3:0] c);
        @(posedge clk) #2;
        if (d) ba = c;
        else ab = c;
        repeat (6) @(posedge clk);
    endtask

    task automatic put(input bit d, input logic [19:0] v);
        @(posedge clk) #2;
        if (d) b_drv = v;
        else a_drv = v;
        repeat (6) @(posedge clk);
    endtask

    task automatic sh(input bit ir, input int n, input logic [87:0] d);
        scan_host_model_i.scan(ir, n, d, scan_out);
    endtask

    task automatic flow(input bit d);
        logic [19:0] v1, v2;
        v1 = 20'($urandom);
        v2 = ~v1;
        ctl(d, 4'b0100);
        put(d, v1);
        note(d, {1'b1, v1});
        ctl(d, 4'b0010);
        put(d, v2);
        note(d, {1'b1, v1});
        ctl(d, 4'b0000);
        note(d, {1'b1, v1});
        ctl(d, 4'b0001);
        note(d, {1'b1, v2});
        put(d, v1);
        ctl(d, 4'b0000);
        note(d, {1'b1, v2});
        ctl(d, 4'b1000);
        note(3, 88'h0);
        $display("Flow test %0d done", d);
    endtask

    // Clear the shadows, load an operation, run it for five idle clocks
    task automatic self_test(input logic [87:0] op, input logic [19:0] e);
        scan_host_model_i.home();
        sh(1, 8, 88'h0A);
        sh(0, 23, op);
        sh(1, 8, 88'h09);
        repeat (5) scan_host_model_i.tick(1'b0, 1'b1, tq);
        repeat (2) @(posedge clk);
        note(0, {1'b1, e});
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watcher pairs each appearing result with the oldest note
    initial begin
        forever begin
            @(result_ev);
            check(seen(sel_q.pop_front()), exp_q.pop_front());
        end
    end

    // Run takes about a tenth of a millisecond
    initial begin
        #400_000;
        mismatches++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h0000_ba9d));
        rst = 1'b1;
        ab = 4'b1000;
        ba = 4'b1000;
        a_drv = 20'h0_0000;
        b_drv = 20'h0_0000;
        repeat (20) @(posedge clk);
        #2 rst = 1'b0;
        flow(1'b0);
        flow(1'b1);
        a_v = 20'($urandom);
        ctl(0, 4'b0100);
        put(0, a_v);
        scan_host_model_i.home();
        sh(0, 32, 88'h0);
        note(2, ID_TB);
        sh(1, 8, 88'h82);
        note(2, 88'h81);
        note(0, {1'b1, a_v});
        sh(1, 8, 88'hFF);
        r = 8'($urandom);
        sh(0, 8, r);
        note(2, {r[6:0], 1'b0});
        sh(1, 8, 88'h81);
        sh(0, 88, 88'h0);
        note(4, {a_v, a_v});
        $display("Normal-mode scan test done");
        sh(1, 8, 88'h00);
        b_v = 20'($urandom);
        din = '0;
        din[87:68] = b_v;
        din[47:28] = ~b_v;
        din[7] = 1'b1;
        sh(0, 88, din);
        put(0, ~a_v);
        note(0, {1'b1, b_v});
        note(3, 88'h2);
        sh(1, 8, 88'h06);
        note(3, 88'h0);
        scan_host_model_i.home();
        put(0, ~a_v);
        note(0, {1'b1, ~a_v});
        $display("Test-mode scan test done");
        self_test(88'h2, 20'h0_001F);
        self_test(88'h3, 20'h0_0005);
        $display("Self-test run test done");
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
